// [core/addr_decode_regs.svh]
// Purpose: named codes for the addressing-mode decoder.
// Assumes: included by bare name; definitions only.
// Notes: opcode rows are the high nibble of the opcode byte.
`ifndef ADDR_DECODE_REGS_SVH
`define ADDR_DECODE_REGS_SVH

// prefix byte values
`define PFX_SECOND_INDEX_CODE 8'h90
`define PFX_SECOND_INDIRECT_CODE 8'h91
`define PFX_INDIRECT_CODE 8'h92

// opcode rows (high nibble)
`define ROW_BIT_REL 4'h0
`define ROW_BIT 4'h1
`define ROW_REL 4'h2
`define ROW_MEM_DIR 4'h3
`define ROW_INH_ACC 4'h4
`define ROW_INH_IDX 4'h5
`define ROW_MEM_IDX 4'h6
`define ROW_MEM_IDX0 4'h7
`define ROW_INH_MISC1 4'h8
`define ROW_INH_MISC2 4'h9
`define ROW_IMM 4'hA
`define ROW_DIR_SHORT 4'hB
`define ROW_DIR_LONG 4'hC
`define ROW_IDX_LONG 4'hD
`define ROW_IDX_SHORT 4'hE
`define ROW_IDX_NONE 4'hF

// opcode columns (low nibble)
`define COL_REL_CALL 4'hD
`define COL_JUMP 4'hC
`define COL_CALL 4'hD

// byte counts
`define BYTES_NONE 2'h0
`define BYTES_ONE 2'h1
`define BYTES_TWO 2'h2
`define LEN_OPCODE 3'h1
`define LEN_STEP 3'h1
`define PC_STEP 16'h0001
`define ADDR_STEP 16'h0001
`define PAGE_ZERO_HI 8'h00
`define ZERO_WORD 16'h0000

`endif

// [core/addr_decode_pkg.sv]
// Purpose: types shared by the addressing-mode decoder modules.
// Assumes: nothing beyond SystemVerilog.
// Notes: widths follow the 8-bit core with a 16-bit address space.
package addr_decode_pkg;

  typedef enum logic [1:0] {
    pfx_none = 2'h0,
    second_index_prefix = 2'h1,
    indirect_prefix = 2'h2,
    second_index_indirect_prefix = 2'h3
  } pfx_t;

  typedef enum logic [3:0] {
    am_inherent = 4'h0,
    am_immediate = 4'h1,
    am_dir_short = 4'h2,
    am_dir_long = 4'h3,
    am_idx_none = 4'h4,
    am_idx_short = 4'h5,
    am_idx_long = 4'h6,
    am_ind_short = 4'h7,
    am_ind_long = 4'h8,
    am_ind_idx_short = 4'h9,
    am_ind_idx_long = 4'hA,
    am_rel_dir = 4'hB,
    am_rel_ind = 4'hC
  } mode_t;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_op = 3'h1,
    st_decode = 3'h2,
    st_arg = 3'h3,
    st_ptr = 3'h4,
    st_disp = 3'h5,
    st_calc = 3'h6
  } state_t;

  typedef struct packed {
    state_t state;
    logic [15:0] pc;
    pfx_t prefix;
    logic [7:0] opcode;
    mode_t mode;
    logic use_y;
    logic illegal;
    logic has_rel;
    logic [1:0] arg_left;
    logic [1:0] ptr_left;
    logic [15:0] word;
    logic [15:0] ptr;
    logic [7:0] disp;
    logic [2:0] length;
    logic prog_rd;
    logic data_rd;
    logic [15:0] data_addr;
    logic busy;
    logic done;
    logic [15:0] eff_addr;
    logic [15:0] branch_target;
    logic [7:0] operand;
  } core_state_t;

endpackage : addr_decode_pkg

// [core/decode_if.sv]
// Purpose: carries opcode and prefix to the classifier and its verdict back.
// Assumes: addr_decode_pkg compiled first.
// Notes: purely combinational bundle, no clocking.
`timescale 1ns/100ps
interface decode_if;
  import addr_decode_pkg::*;
  logic [7:0] opcode;
  pfx_t prefix;
  mode_t mode;
  logic use_y;
  logic [1:0] arg_bytes;
  logic [1:0] ptr_bytes;
  logic has_rel;
  logic illegal;

  modport classifier (
    input opcode,
    input prefix,
    output mode,
    output use_y,
    output arg_bytes,
    output ptr_bytes,
    output has_rel,
    output illegal
  );

  modport core (
    output opcode,
    output prefix,
    input mode,
    input use_y,
    input arg_bytes,
    input ptr_bytes,
    input has_rel,
    input illegal
  );
endinterface : decode_if

// [core/opcode_classifier.sv]
// Purpose: maps prefix and opcode to addressing mode and byte counts.
// Assumes: opcode rows follow the high-nibble layout in the header.
// Notes: combinational; verdict valid while opcode and prefix are stable.
`timescale 1ns/100ps
`include "addr_decode_regs.svh"
module opcode_classifier
  import addr_decode_pkg::*;
(
  decode_if.classifier dif
);
  logic [3:0] row;
  logic [3:0] col;
  logic ind;
  logic ind_y;
  logic rel_row;

  assign row = dif.opcode[7:4];
  assign col = dif.opcode[3:0];
  assign ind = (dif.prefix == indirect_prefix);
  assign ind_y = (dif.prefix == second_index_indirect_prefix);
  assign rel_row = (row == `ROW_REL) || ((row == `ROW_IMM) && (col == `COL_REL_CALL));

  always_comb begin
    dif.mode = am_inherent;
    dif.arg_bytes = `BYTES_NONE;
    dif.ptr_bytes = `BYTES_NONE;
    dif.has_rel = 1'b0;
    dif.use_y = (dif.prefix == second_index_prefix) || ind_y;
    dif.illegal = 1'b0;
    if (rel_row) begin
      if (ind) begin
        dif.mode = am_rel_ind;
        dif.arg_bytes = `BYTES_ONE;
        dif.ptr_bytes = `BYTES_ONE;
      end else begin
        dif.mode = am_rel_dir;
        dif.has_rel = 1'b1;
      end
      dif.illegal = ind_y;
    end else begin
      unique case (row)
        `ROW_BIT_REL, `ROW_BIT, `ROW_MEM_DIR, `ROW_DIR_SHORT: begin
          // bit and memory-modify rows exist only in short form; ROW_DIR_SHORT also has a long form in ROW_DIR_LONG
          dif.arg_bytes = `BYTES_ONE;
          if (ind) begin
            dif.mode = am_ind_short;
            dif.ptr_bytes = `BYTES_ONE;
          end else begin
            dif.mode = am_dir_short;
          end
          dif.has_rel = (row == `ROW_BIT_REL);
          dif.illegal = ind_y;
        end
        `ROW_INH_ACC, `ROW_INH_IDX, `ROW_INH_MISC1, `ROW_INH_MISC2: begin
          dif.mode = am_inherent;
          dif.illegal = ind || ind_y;
        end
        `ROW_IMM: begin
          dif.mode = am_immediate;
          dif.arg_bytes = `BYTES_ONE;
          dif.illegal = ind || ind_y;
        end
        `ROW_MEM_IDX, `ROW_IDX_SHORT: begin
          dif.arg_bytes = `BYTES_ONE;
          if (ind || ind_y) begin
            dif.mode = am_ind_idx_short;
            dif.ptr_bytes = `BYTES_ONE;
          end else begin
            dif.mode = am_idx_short;
          end
        end
        `ROW_MEM_IDX0, `ROW_IDX_NONE: begin
          dif.mode = am_idx_none;
          dif.illegal = ind || ind_y;
        end
        `ROW_DIR_LONG: begin
          if (ind) begin
            dif.mode = am_ind_long;
            dif.arg_bytes = `BYTES_ONE;
            dif.ptr_bytes = `BYTES_TWO;
          end else begin
            dif.mode = am_dir_long;
            dif.arg_bytes = `BYTES_TWO;
          end
          dif.illegal = ind_y || (col == `COL_JUMP) || (col == `COL_CALL);
        end
        `ROW_IDX_LONG: begin
          if (ind || ind_y) begin
            dif.mode = am_ind_idx_long;
            dif.arg_bytes = `BYTES_ONE;
            dif.ptr_bytes = `BYTES_TWO;
          end else begin
            dif.mode = am_idx_long;
            dif.arg_bytes = `BYTES_TWO;
          end
          dif.illegal = (col == `COL_JUMP) || (col == `COL_CALL);
        end
      endcase
    end
  end
endmodule : opcode_classifier

// [core/ea_adder.sv]
// Purpose: unsigned effective-address sum and signed relative target.
// Assumes: index is zero-extended, displacement sign-extended.
// Notes: combinational; 16-bit results wrap in the address space.
`timescale 1ns/100ps
`include "addr_decode_regs.svh"
module ea_adder (
  input wire logic [15:0] base,
  input wire logic [7:0] index,
  input wire logic add_index,
  input wire logic [15:0] pc,
  input wire logic [7:0] disp,
  output logic [15:0] ea,
  output logic [15:0] target
);
  always_comb begin
    ea = base + (add_index ? {`PAGE_ZERO_HI, index} : `ZERO_WORD);
    target = pc + {{8{disp[7]}}, disp};
  end
endmodule : ea_adder

// [core/cpu_addressing_mode_decoder.sv]
// Purpose: fetch prefix, opcode and operand bytes, read pointers, form operand address.
// Assumes: program and data memories answer in the same cycle as their read strobe.
// Notes: one byte per cycle; results stand from the done pulse until the next start.
//
// Notes on behaviour
// - no-operand instructions are one byte only; the code also takes a 90 prefix on them, giving two bytes
// - opcode alone selects a no-operand operation
// - immediate: opcode plus one literal byte
// - short direct: one address byte, page zero
// - long direct: two address bytes, full space
// - indexed address is index plus offset, unsigned
// - indexed no offset: index value alone
// - short indexed: byte offset plus index
// - long indexed: word offset plus index
// - indirect: read pointer at address after opcode
// - short indirect: byte pointer, page zero
// - long indirect forms: byte address, word pointer
// - indirect indexed: pointer plus index, unsigned
// - short indirect indexed: byte pointer plus index
// - arithmetic and load groups take both forms
// - memory-modify, call, jump: short forms only
// - relative: pc plus sign-extended byte
// - relative displacement byte follows the opcode; in bit-test-relative the code takes it after the address byte
// - relative base is the following instruction
// - prefix 90 swaps first index for second
// - prefix 92 turns direct forms indirect
// - prefix 91 selects second index indirect indexed
`timescale 1ns/100ps
`include "addr_decode_regs.svh"
module cpu_addressing_mode_decoder
  import addr_decode_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [15:0] start_pc,
  input wire logic [7:0] x_index,
  input wire logic [7:0] y_index,
  input wire logic [7:0] prog_rdata,
  input wire logic [7:0] data_rdata,
  output logic prog_rd,
  output logic [15:0] prog_addr,
  output logic data_rd,
  output logic [15:0] data_addr,
  output logic busy,
  output logic done,
  output pfx_t prefix,
  output logic [7:0] opcode,
  output mode_t addr_mode,
  output logic use_y,
  output logic illegal,
  output logic [2:0] length,
  output logic [7:0] operand,
  output logic [15:0] eff_addr,
  output logic [15:0] next_pc,
  output logic [15:0] branch_target
);
  core_state_t s_reg;
  core_state_t s_next;

  decode_if dif ();

  logic [15:0] ea_base;
  logic ea_add_index;
  logic [7:0] rel_disp;
  logic [15:0] ea_sum;
  logic [15:0] rel_sum;
  logic [7:0] sel_index;

  assign dif.opcode = s_reg.opcode;
  assign dif.prefix = s_reg.prefix;

  opcode_classifier u_classifier (
    .dif(dif)
  );

  assign sel_index = s_reg.use_y ? y_index : x_index;

  // pick the base word and whether the index joins it
  always_comb begin
    ea_base = s_reg.word;
    ea_add_index = 1'b0;
    unique case (s_reg.mode)
      am_inherent, am_immediate, am_rel_dir, am_rel_ind: begin
        ea_base = `ZERO_WORD;
      end
      am_dir_short, am_dir_long: begin
        ea_base = s_reg.word;
      end
      am_idx_none: begin
        ea_base = `ZERO_WORD;
        ea_add_index = 1'b1;
      end
      am_idx_short, am_idx_long: begin
        ea_base = s_reg.word;
        ea_add_index = 1'b1;
      end
      am_ind_short, am_ind_long: begin
        ea_base = s_reg.ptr;
      end
      am_ind_idx_short, am_ind_idx_long: begin
        ea_base = s_reg.ptr;
        ea_add_index = 1'b1;
      end
    endcase
  end

  // indirect relative takes its displacement from the pointer byte
  assign rel_disp = (s_reg.mode == am_rel_ind) ? s_reg.ptr[7:0] : s_reg.disp;

  ea_adder u_adder (
    .base(ea_base),
    .index(sel_index),
    .add_index(ea_add_index),
    .pc(s_reg.pc),
    .disp(rel_disp),
    .ea(ea_sum),
    .target(rel_sum)
  );

  always_comb begin
    s_next = s_reg;
    s_next.prog_rd = 1'b0;
    s_next.data_rd = 1'b0;
    s_next.done = 1'b0;
    unique case (s_reg.state)
      st_idle: begin
        if (start) begin
          s_next.pc = start_pc;
          s_next.prefix = pfx_none;
          s_next.length = `LEN_OPCODE;
          s_next.illegal = 1'b0;
          s_next.busy = 1'b1;
          s_next.prog_rd = 1'b1;
          s_next.state = st_op;
        end
      end
      st_op: begin
        s_next.pc = s_reg.pc + `PC_STEP;
        // only one prefix is honoured; a second one decodes as an opcode
        if ((s_reg.prefix == pfx_none) && (prog_rdata == `PFX_SECOND_INDEX_CODE)) begin
          s_next.prefix = second_index_prefix;
          s_next.length = s_reg.length + `LEN_STEP;
          s_next.prog_rd = 1'b1;
        end else if ((s_reg.prefix == pfx_none) && (prog_rdata == `PFX_INDIRECT_CODE)) begin
          s_next.prefix = indirect_prefix;
          s_next.length = s_reg.length + `LEN_STEP;
          s_next.prog_rd = 1'b1;
        end else if ((s_reg.prefix == pfx_none)
                     && (prog_rdata == `PFX_SECOND_INDIRECT_CODE)) begin
          s_next.prefix = second_index_indirect_prefix;
          s_next.length = s_reg.length + `LEN_STEP;
          s_next.prog_rd = 1'b1;
        end else begin
          s_next.opcode = prog_rdata;
          s_next.state = st_decode;
        end
      end
      st_decode: begin
        s_next.mode = dif.mode;
        s_next.use_y = dif.use_y;
        s_next.illegal = dif.illegal;
        s_next.has_rel = dif.has_rel;
        s_next.arg_left = dif.arg_bytes;
        s_next.ptr_left = dif.ptr_bytes;
        s_next.word = `ZERO_WORD;
        s_next.ptr = `ZERO_WORD;
        s_next.disp = `PAGE_ZERO_HI;
        s_next.length = s_reg.length + {1'b0, dif.arg_bytes} + {2'b00, dif.has_rel};
        if (dif.arg_bytes != `BYTES_NONE) begin
          s_next.prog_rd = 1'b1;
          s_next.state = st_arg;
        end else if (dif.has_rel) begin
          s_next.prog_rd = 1'b1;
          s_next.state = st_disp;
        end else begin
          s_next.state = st_calc;
        end
      end
      st_arg: begin
        s_next.word = {s_reg.word[7:0], prog_rdata};
        s_next.pc = s_reg.pc + `PC_STEP;
        s_next.arg_left = s_reg.arg_left - `BYTES_ONE;
        if (s_reg.arg_left != `BYTES_ONE) begin
          s_next.prog_rd = 1'b1;
        end else if (s_reg.ptr_left != `BYTES_NONE) begin
          // pointer address is one byte, so pointers start in page zero
          s_next.data_addr = {`PAGE_ZERO_HI, prog_rdata};
          s_next.data_rd = 1'b1;
          s_next.state = st_ptr;
        end else if (s_reg.has_rel) begin
          s_next.prog_rd = 1'b1;
          s_next.state = st_disp;
        end else begin
          s_next.state = st_calc;
        end
      end
      st_ptr: begin
        s_next.ptr = {s_reg.ptr[7:0], data_rdata};
        s_next.ptr_left = s_reg.ptr_left - `BYTES_ONE;
        if (s_reg.ptr_left != `BYTES_ONE) begin
          s_next.data_addr = s_reg.data_addr + `ADDR_STEP;
          s_next.data_rd = 1'b1;
        end else if (s_reg.has_rel) begin
          s_next.prog_rd = 1'b1;
          s_next.state = st_disp;
        end else begin
          s_next.state = st_calc;
        end
      end
      st_disp: begin
        s_next.disp = prog_rdata;
        s_next.pc = s_reg.pc + `PC_STEP;
        s_next.state = st_calc;
      end
      st_calc: begin
        // pc already points past the last byte of this instruction
        s_next.eff_addr = ea_sum;
        s_next.branch_target = rel_sum;
        s_next.operand = s_reg.word[7:0];
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.state = st_idle;
      end
      default: begin
        s_next.busy = 1'b0;
        s_next.state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prog_rd = s_reg.prog_rd;
  assign prog_addr = s_reg.pc;
  assign data_rd = s_reg.data_rd;
  assign data_addr = s_reg.data_addr;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign prefix = s_reg.prefix;
  assign opcode = s_reg.opcode;
  assign addr_mode = s_reg.mode;
  assign use_y = s_reg.use_y;
  assign illegal = s_reg.illegal;
  assign length = s_reg.length;
  assign operand = s_reg.operand;
  assign eff_addr = s_reg.eff_addr;
  assign next_pc = s_reg.pc;
  assign branch_target = s_reg.branch_target;
endmodule : cpu_addressing_mode_decoder

// [bench/addr_decode_props.sv]
// Purpose: port checks on the addressing-mode decoder.
// Assumes: index inputs held steady through a decode.
// Notes: bound to every decoder instance.
`timescale 1ns/100ps
module addr_decode_props
  import addr_decode_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [15:0] start_pc,
  input wire logic [7:0] x_index,
  input wire logic [7:0] y_index,
  input wire logic [7:0] prog_rdata,
  input wire logic [7:0] data_rdata,
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  input wire logic data_rd,
  input wire logic [15:0] data_addr,
  input wire logic busy,
  input wire logic done,
  input wire pfx_t prefix,
  input wire logic [7:0] opcode,
  input wire mode_t addr_mode,
  input wire logic use_y,
  input wire logic illegal,
  input wire logic [2:0] length,
  input wire logic [7:0] operand,
  input wire logic [15:0] eff_addr,
  input wire logic [15:0] next_pc,
  input wire logic [15:0] branch_target
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] pc0_reg;
  // start address of the decode in flight, for the length relation
  always_ff @(posedge clk) begin
    if (start && !busy)
      pc0_reg <= start_pc;
  end
  one_byte_a: assert property (done && addr_mode == am_inherent && prefix == pfx_none
    |-> length == 3'h1) else $error("inherent length wrong");
  imm_len_a: assert property (done && addr_mode == am_immediate
    |-> length == 3'(2 + (prefix != pfx_none))) else $error("immediate length wrong");
  page_zero_a: assert property (done && addr_mode == am_dir_short
    |-> eff_addr[15:8] == 8'h00) else $error("short direct left page zero");
  idx_none_a: assert property (done && addr_mode == am_idx_none
    |-> eff_addr == {8'h00, use_y ? $past(y_index) : $past(x_index)}) else $error("bad index");
  idx_span_a: assert property (done && addr_mode == am_idx_short
    |-> eff_addr <= 16'h01FE) else $error("short indexed out of span");
  ptr_span_a: assert property (done && addr_mode == am_ind_idx_short
    |-> eff_addr <= 16'h01FE) else $error("short indirect indexed out of span");
  // the displacement byte is on the program bus two edges before done
  rel_target_a: assert property (done && addr_mode == am_rel_dir
    |-> branch_target == next_pc + {{8{$past(prog_rdata, 2)[7]}}, $past(prog_rdata, 2)})
    else $error("bad target");
  next_base_a: assert property (done |-> next_pc == pc0_reg + 16'(length))
    else $error("next pc not after instruction");
  fetch_order_a: assert property (prog_rd && $past(prog_rd)
    |-> prog_addr == $past(prog_addr) + 16'h0001) else $error("program fetch not ascending");
  ptr_pair_a: assert property (data_rd && $past(data_rd)
    |-> data_addr == $past(data_addr) + 16'h0001) else $error("pointer bytes not paired");
  y_select_a: assert property (done && prefix == second_index_indirect_prefix
    |-> use_y) else $error("second index not selected");
endmodule : addr_decode_props
bind cpu_addressing_mode_decoder addr_decode_props addr_decode_props_i (.*);

// [bench/code_data_mem.sv]
// Purpose: program and data memory answering the decoder.
// Assumes: reads answer in the strobe cycle.
// Notes: the bench loads both arrays directly.
`timescale 1ns/100ps
module code_data_mem (
  input wire logic clk,
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  input wire logic data_rd,
  input wire logic [15:0] data_addr,
  output logic [7:0] prog_rdata,
  output logic [7:0] data_rdata
);
  logic [7:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  logic [7:0] plast = 8'hA5;
  logic [7:0] dlast = 8'h5A;
  // a released bus shows the inverse of its last byte, so stale data never passes
  assign prog_rdata = prog_rd ? pm[prog_addr] : ~plast;
  assign data_rdata = data_rd ? dm[data_addr] : ~dlast;
  always @(posedge clk) begin
    if (prog_rd)
      plast <= pm[prog_addr];
    if (data_rd)
      dlast <= dm[data_addr];
  end
endmodule : code_data_mem

// [bench/tb_top.sv]
// Purpose: self-checking bench for the addressing-mode decoder.
// Assumes: done follows each accepted start.
// Notes: corner walk over every case, then random back-to-back decodes.
`timescale 1ns/100ps
module tb_top;
  import addr_decode_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [15:0] start_pc = 16'h0000;
  logic [7:0] x_index = 8'h00;
  logic [7:0] y_index = 8'h00;
  logic [7:0] prog_rdata;
  logic [7:0] data_rdata;
  logic prog_rd;
  logic [15:0] prog_addr;
  logic data_rd;
  logic [15:0] data_addr;
  logic busy;
  logic done;
  pfx_t prefix;
  logic [7:0] opcode;
  mode_t addr_mode;
  logic use_y;
  logic illegal;
  logic [2:0] length;
  logic [7:0] operand;
  logic [15:0] eff_addr;
  logic [15:0] next_pc;
  logic [15:0] branch_target;
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h9270272F;
  // prefix, opcode, mode, operand bytes, pointer bytes, second index, refused
  // last entry is a bit-test-relative: address byte then displacement byte
  logic [31:0] cases [26] = '{32'h00800000, 32'h004C0000, 32'h00A61100, 32'h00B62100,
    32'h003C2100, 32'h00C63200, 32'h00CB3200, 32'h00F64000, 32'h90F64002, 32'h00E65100,
    32'h90E65102, 32'h00D66200, 32'h00D56200, 32'h92B67110, 32'h92C68120, 32'h92E69110,
    32'h91E69112, 32'h92D6A120, 32'h91D6A122, 32'h0027B100, 32'h00ADB100, 32'h9227C110,
    32'h00CC3201, 32'h00BC2100, 32'h92800001, 32'h00002200};
  cpu_addressing_mode_decoder cpu_addressing_mode_decoder_i (.*);
  code_data_mem code_data_mem_i (.*);
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  function automatic logic [1:0] exp_pfx(input logic [7:0] b);
    case (b)
      8'h90: return 2'h1;
      8'h92: return 2'h2;
      8'h91: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : exp_pfx
  function automatic logic [15:0] exp_ea(input logic [31:0] c, input logic [7:0] a0,
      input logic [7:0] a1, input logic [7:0] ix);
    logic [15:0] w;
    logic [15:0] pw;
    w = (c[15:12] == 4'h3 || c[15:12] == 4'h6) ? {a0, a1} : {8'h00, a0};
    pw = {8'h00, code_data_mem_i.dm[a0]};
    // word pointer: high byte at the lower address, no page wrap
    if (c[7:4] == 4'h2)
      pw = {code_data_mem_i.dm[a0], code_data_mem_i.dm[16'(a0) + 16'h0001]};
    case (mode_t'(c[15:12]))
      am_dir_short, am_dir_long: return w;
      am_idx_none: return {8'h00, ix};
      am_idx_short, am_idx_long: return w + {8'h00, ix};
      am_ind_short, am_ind_long: return pw;
      am_ind_idx_short, am_ind_idx_long: return pw + {8'h00, ix};
      default: return 16'h0000;
    endcase
  endfunction : exp_ea
  task automatic run(input logic [31:0] c, input logic junk, input logic corner);
    logic [15:0] pc;
    logic [15:0] tgt;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] d;
    int p;
    int len;
    int k;
    pc = 16'($random(seed));
    a0 = corner ? 8'hFF : 8'($random(seed));
    a1 = 8'($random(seed));
    x_index = corner ? 8'hFF : 8'($random(seed));
    y_index = corner ? 8'hFF : 8'($random(seed));
    p = int'(c[31:24] != 8'h00);
    len = p + 1 + int'(c[11:8]);
    if (p == 1) begin
      code_data_mem_i.pm[pc] = c[31:24];
    end
    code_data_mem_i.pm[pc + 16'(p)] = c[23:16];
    code_data_mem_i.pm[pc + 16'(p + 1)] = a0;
    code_data_mem_i.pm[pc + 16'(p + 2)] = a1;
    d = (c[15:12] == 4'hC) ? code_data_mem_i.dm[a0] : ((c[23:20] == 4'h0) ? a1 : a0);
    tgt = pc + 16'(len) + {{8{d[7]}}, d};
    start_pc = pc;
    start = 1'b1;
    k = 0;
    // an extra start while busy must be ignored
    do begin
      @(negedge clk);
      k++;
      if (done !== 1'b1) begin
        start = junk && k == 2;
      end
    end while (done !== 1'b1 && k < 20);
    chk(16'(k), 16'(3 + len + int'(c[7:4])));
    chk(16'(opcode), 16'(c[23:16]));
    chk(16'(prefix), 16'(exp_pfx(c[31:24])));
    chk(16'(addr_mode), 16'(c[15:12]));
    chk(16'(length), 16'(len));
    chk(16'(use_y), 16'(c[1]));
    chk(16'(illegal), 16'(c[0]));
    chk(eff_addr, exp_ea(c, a0, a1, c[1] ? y_index : x_index));
    chk(next_pc, pc + 16'(len));
    chk(16'(busy), 16'h0000);
    if (c[15:12] == 4'h1) begin
      chk(16'(operand), 16'(a0));
    end
    if (c[15:12] >= 4'hB || c[23:20] == 4'h0) begin
      chk(branch_target, tgt);
    end
  endtask : run
  initial begin
    for (int i = 0; i < 65536; i++) begin
      code_data_mem_i.dm[i] = 8'($random(seed));
    end
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 26; i++) begin
      run(cases[i], 1'b0, 1'b1);
    end
    $display("corner walk finished");
    for (int i = 0; i < 300; i++) begin
      run(cases[$unsigned($random(seed)) % 26], 1'($random(seed)), 1'b0);
    end
    $display("random walk finished");
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule : tb_top
